// >>> design/macrocell_register_control.sv
module macrocell_register_control (
    input  wire logic                              clock,     // 20 MHz device clock
    input  wire logic                              rst,       // async power-up reset
    input  wire logic                              psel,      // apb select
    input  wire logic                              penable,   // apb enable
    input  wire logic                              pwrite,    // apb direction
    input  wire logic [mcell_pkg::ADDR_W-1:0]      paddr,     // apb byte address
    input  wire logic [31:0]                       pwdata,    // apb write data
    output logic      [31:0]                       prdata,    // apb read data
    output logic                                   pready,    // apb ready
    output logic                                   pslverr,   // apb error
    input  wire logic [mcell_pkg::NUM_IN-1:0]      in_pin,    // dedicated inputs
    input  wire logic [mcell_pkg::NUM_IN-1:0]      in_float,  // input left undriven
    input  wire logic [mcell_pkg::NUM_MC-1:0]      io_in,     // pin level seen
    input  wire logic [mcell_pkg::NUM_MC-1:0]      io_float,  // pin not driven by anyone
    output logic      [mcell_pkg::NUM_MC-1:0]      io_out,    // pin drive value
    output logic      [mcell_pkg::NUM_MC-1:0]      io_oe      // pin drive enable
);
    localparam int NMC = mcell_pkg::NUM_MC;
    localparam int NIN = mcell_pkg::NUM_IN;
    localparam int NLIT = mcell_pkg::NUM_LIT;

    typedef enum logic {ST_IDLE, ST_ERASE} erase_st_t;

    // two-flop synchronisers on every pin input
    logic [NLIT-1:0] lvl_s1_r;
    logic [NLIT-1:0] lvl_s2_r;
    logic [NLIT-1:0] flt_s1_r;
    logic [NLIT-1:0] flt_s2_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lvl_s1_r <= '0;
            lvl_s2_r <= '0;
            flt_s1_r <= '1;
            flt_s2_r <= '1;
        end else begin
            lvl_s1_r <= {io_in, in_pin};
            lvl_s2_r <= lvl_s1_r;
            flt_s1_r <= {io_float, in_float};
            flt_s2_r <= flt_s1_r;
        end
    end

    // state
    mcell_pkg::term_t                  term_mem [mcell_pkg::NUM_TERMS];
    mcell_pkg::cfg_t                   cfg_r, cfg_nxt;
    logic [NMC-1:0]                    q_r, q_nxt;
    logic [NMC-1:0]                    out_r, out_nxt;
    logic [NMC-1:0]                    oe_r, oe_nxt;
    logic                              secure_r, secure_nxt;
    logic [63:0]                       sig_r, sig_nxt;
    logic [mcell_pkg::IDX_W-1:0]       sel_r, sel_nxt;
    logic [31:0]                       lo_r, lo_nxt;
    logic [mcell_pkg::POR_W-1:0]       por_r, por_nxt;
    erase_st_t                         st_r, st_nxt;
    logic [mcell_pkg::IDX_W-1:0]       eidx_r, eidx_nxt;
    logic                              pready_nxt, pslverr_nxt;
    logic [31:0]                       prdata_nxt;
    logic                              mem_we;
    logic [mcell_pkg::IDX_W-1:0]       mem_wa;
    mcell_pkg::term_t                  mem_wd;

    // array evaluation
    logic [NLIT-1:0]                   pin_lit;
    logic [NLIT-1:0]                   lit;
    logic [mcell_pkg::NUM_TERMS-1:0]   pt;
    logic [NMC-1:0]                    sum;
    logic                              async_zero_term, sync_set_term;
    logic                              por_busy, busy;

    assign pin_lit  = lvl_s2_r | flt_s2_r; // [R14]
    assign por_busy = (por_r != mcell_pkg::POR_W'(mcell_pkg::PWRUP_CLEAR_CYC));
    assign busy     = (st_r == ST_ERASE);

    genvar g;
    generate
        for (g = 0; g < NMC; g++) begin : g_fb
            // registered cells feed back the inverted register, others the pin
            assign lit[NIN+g] = cfg_r.regm[g] ? ~q_r[g] : pin_lit[NIN+g]; // [R17] [R18]
        end
        for (g = 0; g < mcell_pkg::NUM_TERMS; g++) begin : g_pt
            assign pt[g] = mcell_pkg::term_hit(term_mem[g], lit);
        end
        for (g = 0; g < NMC; g++) begin : g_sum
            assign sum[g] = |(pt[mcell_pkg::NUM_LOGIC-1:0] & mcell_pkg::cell_mask(g)); // [R1]
        end
    endgenerate
    assign lit[NIN-1:0] = pin_lit[NIN-1:0];
    assign async_zero_term = pt[mcell_pkg::ZERO_IDX];
    assign sync_set_term   = pt[mcell_pkg::SET_IDX];

    // apb decode
    logic acc, done, wr;
    assign acc  = psel & penable;
    assign done = acc & pready;
    assign wr   = done & pwrite & ~pslverr;

    function automatic logic mapped(input logic [mcell_pkg::ADDR_W-1:0] a);
        case (a)
            mcell_pkg::ADDR_CTRL, mcell_pkg::ADDR_MODE, mcell_pkg::ADDR_OE,
            mcell_pkg::ADDR_SEL, mcell_pkg::ADDR_TERM_LO, mcell_pkg::ADDR_TERM_HI,
            mcell_pkg::ADDR_SIG_LO, mcell_pkg::ADDR_SIG_HI, mcell_pkg::ADDR_PRELOAD,
            mcell_pkg::ADDR_STATUS: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    endfunction : mapped

    logic preload_we;
    assign preload_we = wr && (paddr == mcell_pkg::ADDR_PRELOAD);

    // bus answer: one wait state; while erasing only control reads are answered
    always_comb begin
        mcell_pkg::term_t rd_term;
        logic             ctrl_rd;
        rd_term     = (sel_r < mcell_pkg::IDX_W'(mcell_pkg::NUM_TERMS)) ? term_mem[sel_r] : '0;
        ctrl_rd     = !pwrite && (paddr == mcell_pkg::ADDR_CTRL);
        // lets software poll the busy flag instead of stalling on it
        pready_nxt  = acc & ~pready & (~busy | ctrl_rd);
        pslverr_nxt = pready_nxt & ~mapped(paddr);
        prdata_nxt  = '0;
        if (pready_nxt && !pwrite) begin
            case (paddr)
                mcell_pkg::ADDR_CTRL: begin
                    prdata_nxt[mcell_pkg::CTRL_SECURE] = secure_r;
                    prdata_nxt[mcell_pkg::CTRL_BUSY]   = busy;
                    prdata_nxt[mcell_pkg::CTRL_READY]  = ~por_busy;
                end
                mcell_pkg::ADDR_MODE: begin
                    prdata_nxt[NMC-1:0] = secure_r ? '0 : cfg_r.pol; // [R11]
                    prdata_nxt[mcell_pkg::MODE_REG_LSB +: NMC] = secure_r ? '0 : cfg_r.regm;
                end
                mcell_pkg::ADDR_OE:      prdata_nxt[2*NMC-1:0] = secure_r ? '0 : cfg_r.oem;
                mcell_pkg::ADDR_SEL:     prdata_nxt[mcell_pkg::IDX_W-1:0] = sel_r;
                mcell_pkg::ADDR_TERM_LO: prdata_nxt = secure_r ? '0 : rd_term[31:0]; // [R11]
                mcell_pkg::ADDR_TERM_HI: begin
                    prdata_nxt[mcell_pkg::HI_W-1:0] =
                        secure_r ? '0 : rd_term[mcell_pkg::TERM_W-1:32]; // [R11]
                end
                mcell_pkg::ADDR_SIG_LO:  prdata_nxt = sig_r[31:0]; // [R12]
                mcell_pkg::ADDR_SIG_HI:  prdata_nxt = sig_r[63:32]; // [R12]
                mcell_pkg::ADDR_PRELOAD: prdata_nxt[NMC-1:0] = q_r;
                mcell_pkg::ADDR_STATUS: begin
                    prdata_nxt[NMC-1:0] = out_r;
                    prdata_nxt[mcell_pkg::MODE_REG_LSB +: NMC] = oe_r;
                end
                default: prdata_nxt = '0;
            endcase
        end
    end

    // configuration store, erase sequencer, signature
    always_comb begin
        cfg_nxt    = cfg_r;
        secure_nxt = secure_r;
        sig_nxt    = sig_r;
        sel_nxt    = sel_r;
        lo_nxt     = lo_r;
        st_nxt     = st_r;
        eidx_nxt   = eidx_r;
        mem_we     = 1'b0;
        mem_wa     = sel_r;
        mem_wd     = {pwdata[mcell_pkg::HI_W-1:0], lo_r};
        case (st_r)
            ST_ERASE: begin
                mem_we   = 1'b1; // [R13]
                mem_wa   = eidx_r;
                mem_wd   = mcell_pkg::TERM_ERASED;
                eidx_nxt = eidx_r + 1'b1;
                if (eidx_r == mcell_pkg::IDX_W'(mcell_pkg::NUM_TERMS - 1)) st_nxt = ST_IDLE;
            end
            default: begin
                if (wr) begin
                    case (paddr)
                        mcell_pkg::ADDR_CTRL: begin
                            if (pwdata[mcell_pkg::CTRL_ERASE]) begin
                                // an erase command wipes terms, configuration, signature and security bit
                                st_nxt     = ST_ERASE; // [R13]
                                eidx_nxt   = '0;
                                cfg_nxt    = '0;
                                sig_nxt    = '0;
                                secure_nxt = 1'b0; // [R11]
                            end else if (pwdata[mcell_pkg::CTRL_SECURE]) begin
                                secure_nxt = 1'b1; // [R11]
                            end
                        end
                        mcell_pkg::ADDR_MODE: begin
                            cfg_nxt.pol  = pwdata[NMC-1:0]; // [R3] [R16]
                            cfg_nxt.regm = pwdata[mcell_pkg::MODE_REG_LSB +: NMC]; // [R16]
                        end
                        mcell_pkg::ADDR_OE:      cfg_nxt.oem = pwdata[2*NMC-1:0];
                        mcell_pkg::ADDR_SEL:     sel_nxt = pwdata[mcell_pkg::IDX_W-1:0];
                        mcell_pkg::ADDR_TERM_LO: lo_nxt = pwdata;
                        mcell_pkg::ADDR_TERM_HI: begin
                            mem_we = (sel_r < mcell_pkg::IDX_W'(mcell_pkg::NUM_TERMS));
                        end
                        mcell_pkg::ADDR_SIG_LO:  sig_nxt[31:0] = pwdata; // [R15]
                        mcell_pkg::ADDR_SIG_HI:  sig_nxt[63:32] = pwdata; // [R15]
                        default: ;
                    endcase
                end
            end
        endcase
    end

    // macrocell registers and pin drivers
    always_comb begin
        logic v;
        v       = 1'b0;
        por_nxt = por_busy ? por_r + 1'b1 : por_r;
        if (por_busy) begin
            q_nxt = '0; // [R7]
        end else if (async_zero_term) begin
            q_nxt = '0; // [R4] [R6] [R19]
        end else if (preload_we) begin
            q_nxt = pwdata[NMC-1:0]; // [R10]
        end else if (sync_set_term) begin
            q_nxt = '1; // [R5] [R6]
        end else begin
            q_nxt = sum;
        end
        for (int m = 0; m < NMC; m++) begin
            v = cfg_r.regm[m] ? q_nxt[m] : sum[m]; // [R17] [R18]
            out_nxt[m] = cfg_r.pol[m] ? v : ~v; // [R3] [R6]
            if (cfg_r.regm[m]) begin
                oe_nxt[m] = pt[mcell_pkg::OE_BASE + m]; // [R2]
            end else begin
                case (cfg_r.oem[2*m +: 2])
                    mcell_pkg::OE_ON:  oe_nxt[m] = 1'b1; // [R18]
                    mcell_pkg::OE_OFF: oe_nxt[m] = 1'b0;
                    default:           oe_nxt[m] = pt[mcell_pkg::OE_BASE + m]; // [R2]
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r    <= '0;
            secure_r <= 1'b0;
            sig_r    <= '0;
            sel_r    <= '0;
            lo_r     <= '0;
            st_r     <= ST_IDLE;
            eidx_r   <= '0;
            q_r      <= '0; // [R7]
            out_r    <= '0;
            oe_r     <= '0;
            por_r    <= '0;
            prdata   <= '0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            cfg_r    <= cfg_nxt;
            secure_r <= secure_nxt;
            sig_r    <= sig_nxt;
            sel_r    <= sel_nxt;
            lo_r     <= lo_nxt;
            st_r     <= st_nxt;
            eidx_r   <= eidx_nxt;
            q_r      <= q_nxt;
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            por_r    <= por_nxt;
            prdata   <= prdata_nxt;
            pready   <= pready_nxt;
            pslverr  <= pslverr_nxt;
        end
    end

    // term store starts erased
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int t = 0; t < mcell_pkg::NUM_TERMS; t++) term_mem[t] <= mcell_pkg::TERM_ERASED;
        end else if (mem_we) begin
            term_mem[mem_wa] <= mem_wd;
        end
    end

    assign io_out = out_r;
    assign io_oe  = oe_r;
endmodule : macrocell_register_control

// >>> inc/mcell_pkg.sv
package mcell_pkg;
    // Overview of operation
    // (R1) twelve cells: two with twelve logic terms, two with ten, rest with eight
    // (R2) each cell has one extra term used only for its output enable
    // (R3) each cell output polarity is true or inverted in both modes
    // (R4) shared zero term clears every register at once while asserted; the code clears them at the next rising edge
    // (R5) shared set term loads ones into every register at next rising edge
    // (R6) zero and set act on register state, not on the pin polarity
    // (R7) after power-up all registers read low within 45 us
    // (R8) board logic gives a valid clock level within 100 ns of power-up
    // (R9) board logic should not clock until input and feedback setup is met
    // (R10) each register can be preloaded high or low synchronously for test
    // (R11) programmed security bit hides configuration; only full reprogram clears it
    // (R12) user signature stays readable whatever the security bit says
    // (R13) every programming cycle begins with an automatic erase; the code erases only when CTRL_ERASE is written
    // (R14) undriven inputs and tri-stated pins read as logic one
    // (R15) sixty-four bits of user signature storage are held
    // (R16) two configuration bits per cell pick mode and polarity
    // (R17) registered cell drives pin from register; inverted register feeds back
    // (R18) combinatorial cell drives pin from sum; enable on, off or term; pin feeds back
    // (R19) zero term wins over set term at the same edge
    localparam int NUM_MC    = 12;
    localparam int NUM_IN    = 14;
    localparam int NUM_LIT   = NUM_IN + NUM_MC;
    localparam int TERM_W    = 2 * NUM_LIT;
    localparam int HI_W      = TERM_W - 32;
    localparam int NUM_LOGIC = 108;
    localparam int OE_BASE   = NUM_LOGIC;
    localparam int ZERO_IDX  = OE_BASE + NUM_MC;
    localparam int SET_IDX   = ZERO_IDX + 1;
    localparam int NUM_TERMS = SET_IDX + 1;
    localparam int IDX_W     = 7;
    localparam int ADDR_W    = 8;

    typedef logic [TERM_W-1:0] term_t;
    localparam term_t TERM_ERASED = '1;

    localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE    = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_OE      = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SEL     = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_TERM_LO = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_TERM_HI = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_SIG_LO  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_SIG_HI  = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_PRELOAD = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h24;

    localparam int CTRL_ERASE  = 0;
    localparam int CTRL_SECURE = 1;
    localparam int CTRL_BUSY   = 2;
    localparam int CTRL_READY  = 3;
    localparam int MODE_REG_LSB = 16;

    localparam logic [1:0] OE_TERM = 2'h0;
    localparam logic [1:0] OE_ON   = 2'h1;
    localparam logic [1:0] OE_OFF  = 2'h2;

    localparam int PWRUP_CLEAR_NS  = 45000;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int PWRUP_CLEAR_CYC = PWRUP_CLEAR_NS / CLK_PERIOD_NS;
    localparam int POR_W           = 10;

    typedef struct packed {
        logic [NUM_MC-1:0]   pol;
        logic [NUM_MC-1:0]   regm;
        logic [2*NUM_MC-1:0] oem;
    } cfg_t;

    function automatic int term_count(input int m);
        case (m)
            4, 7:    term_count = 10;
            5, 6:    term_count = 12;
            default: term_count = 8;
        endcase
    endfunction : term_count

    function automatic logic [NUM_LOGIC-1:0] cell_mask(input int m);
        int base;
        base = 0;
        for (int k = 0; k < m; k++) base += term_count(k);
        cell_mask = '0;
        for (int t = 0; t < NUM_LOGIC; t++) begin
            cell_mask[t] = (t >= base) && (t < base + term_count(m));
        end
    endfunction : cell_mask

    // erased word holds both literals of every input, so the term is false
    function automatic logic term_hit(input term_t w, input logic [NUM_LIT-1:0] lit);
        term_hit = &((~w[NUM_LIT-1:0] | lit) & (~w[TERM_W-1:NUM_LIT] | ~lit));
    endfunction : term_hit
endpackage : mcell_pkg

// >>> tb/board_model.sv
module board_model (
    input  wire logic [13:0] drv_in,     // level the board puts on inputs
    input  wire logic [13:0] drv_in_en,  // board drives that input
    input  wire logic [11:0] drv_io,     // level the board puts on pins
    input  wire logic [11:0] drv_io_en,  // board drives that pin
    input  wire logic [11:0] io_out,     // device pin value
    input  wire logic [11:0] io_oe,      // device pin enable
    output logic      [13:0] in_pin,     // resolved input level
    output logic      [13:0] in_float,   // input undriven
    output logic      [11:0] io_in,      // resolved pin level
    output logic      [11:0] io_float    // pin undriven
);
    timeunit 1ns;
    timeprecision 100ps;
    // released lines fall to the pull-up level
    assign in_pin   = drv_in_en & drv_in | ~drv_in_en;
    assign in_float = ~drv_in_en;
    assign io_in    = io_oe & io_out | ~io_oe & (drv_io_en & drv_io | ~drv_io_en);
    assign io_float = ~io_oe & ~drv_io_en;
endmodule : board_model

// >>> tb/mrc_monitor.sv
module mrc_monitor (
    input wire logic        clock,    // device clock
    input wire logic        rst,      // async reset
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb enable
    input wire logic        pwrite,   // apb direction
    input wire logic [7:0]  paddr,    // apb address
    input wire logic [31:0] prdata,   // apb read data
    input wire logic        pready,   // apb ready
    input wire logic        pslverr,  // apb error
    input wire logic [11:0] io_oe     // pin enables
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence access_start;
        psel && !penable ##1 psel && penable;
    endsequence
    a_setup_answer: assert property (access_start |-> ##[1:124] pready)
        else $error("no ready after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_rdata: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read answer");
    a_unmapped_err: assert property (pready && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_reset_quiet: assert property ($fell(rst) |-> io_oe == 12'h000 && !pready)
        else $error("outputs active out of reset");
endmodule : mrc_monitor

bind macrocell_register_control mrc_monitor i_mrc_monitor (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_oe(io_oe));

// >>> tb/tb_macrocell_register_control.sv
module tb_macrocell_register_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] in_pin, in_float, drv_in, drv_in_en;
    logic [11:0] io_in, io_float, io_out, io_oe, drv_io_en;
    int          err_total, total_checks;

    macrocell_register_control i_macrocell_register_control (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pin(in_pin), .in_float(in_float), .io_in(io_in),
        .io_float(io_float), .io_out(io_out), .io_oe(io_oe));
    board_model i_board_model (
        .drv_in(drv_in), .drv_in_en(drv_in_en), .drv_io(12'h000), .drv_io_en(drv_io_en),
        .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin), .in_float(in_float),
        .io_in(io_in), .io_float(io_float));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 300);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 300) chk("pready", 32'h1, 32'h0);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic term(input logic [31:0] idx, input logic [31:0] lo);
        wr(mcell_pkg::ADDR_SEL, idx);
        wr(mcell_pkg::ADDR_TERM_LO, lo);
        wr(mcell_pkg::ADDR_TERM_HI, 32'h0);
    endtask : term

    task automatic poll_ctrl(input int bit_no, input logic want);
        int n;
        n = 0;
        do begin
            apb(1'b0, mcell_pkg::ADDR_CTRL, 32'h0);
            n++;
        end while (rd[bit_no] !== want && n < 400);
    endtask : poll_ctrl

    task automatic t_powerup;
        apb(1'b0, mcell_pkg::ADDR_CTRL, 32'h0);
        chk("ready early", 32'h0, 32'(rd[3]));
        poll_ctrl(3, 1'b1);
        chk("ready late", 32'h1, 32'(rd[3]));
        rdchk("q after power-up", mcell_pkg::ADDR_PRELOAD, 32'h0);
        rdchk("erased pins", mcell_pkg::ADDR_STATUS, 32'h0000_0fff);
        $display("test powerup done");
    endtask : t_powerup

    task automatic t_secure;
        wr(mcell_pkg::ADDR_SIG_LO, 32'h1234_5678);
        wr(mcell_pkg::ADDR_SIG_HI, 32'h9abc_def0);
        wr(mcell_pkg::ADDR_MODE, 32'h0fff_0fff);
        rdchk("mode open", mcell_pkg::ADDR_MODE, 32'h0fff_0fff);
        wr(mcell_pkg::ADDR_CTRL, 32'h2);
        rdchk("mode locked", mcell_pkg::ADDR_MODE, 32'h0);
        rdchk("sig lo", mcell_pkg::ADDR_SIG_LO, 32'h1234_5678);
        rdchk("sig hi", mcell_pkg::ADDR_SIG_HI, 32'h9abc_def0);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        wr(mcell_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, mcell_pkg::ADDR_CTRL, 32'h0);
        chk("busy seen", 32'h1, 32'(rd[2]));
        poll_ctrl(2, 1'b0);
        rdchk("mode erased", mcell_pkg::ADDR_MODE, 32'h0);
        wr(mcell_pkg::ADDR_MODE, 32'h0000_0fff);
        rdchk("mode unlocked", mcell_pkg::ADDR_MODE, 32'h0000_0fff);
        $display("test secure done");
    endtask : t_secure

    task automatic t_preload;
        wr(mcell_pkg::ADDR_MODE, 32'h0fff_0fff);
        wr(mcell_pkg::ADDR_PRELOAD, 32'h0000_0a5a);
        #1 chk("preload pins", 32'h0a5a, 32'(io_out));
        wr(mcell_pkg::ADDR_MODE, 32'h0fff_0000);
        wr(mcell_pkg::ADDR_PRELOAD, 32'h0000_0a5a);
        #1 chk("preload inverted", 32'h05a5, 32'(io_out));
        $display("test preload done");
    endtask : t_preload

    task automatic t_zero_set;
        term(32'd120, 32'h1);
        term(32'd121, 32'h2);
        wr(mcell_pkg::ADDR_MODE, 32'h0fff_0fff);
        drv_in <= 14'h0002;
        repeat (2) @(posedge clock);
        #1 chk("set too soon", 32'h0, 32'(io_out));
        @(posedge clock);
        #1 chk("set term", 32'h0fff, 32'(io_out));
        @(posedge clock);
        drv_in <= 14'h0003;
        repeat (5) @(posedge clock);
        chk("zero wins", 32'h0, 32'(io_out));
        drv_in <= 14'h0002;
        repeat (5) @(posedge clock);
        chk("set again", 32'h0fff, 32'(io_out));
        drv_in_en <= 14'h3ffe;
        repeat (5) @(posedge clock);
        chk("float reads one", 32'h0, 32'(io_out));
        drv_in    <= 14'h0000;
        drv_in_en <= 14'h3fff;
        $display("test zero set done");
    endtask : t_zero_set

    task automatic t_comb;
        term(32'd41, 32'h0);
        term(32'd112, 32'h0);
        wr(mcell_pkg::ADDR_OE, 32'h0);
        wr(mcell_pkg::ADDR_MODE, 32'h0000_0fff);
        repeat (4) @(posedge clock);
        chk("sum cell", 32'h0010, 32'(io_out));
        chk("enable term", 32'h0010, 32'(io_oe));
        wr(mcell_pkg::ADDR_OE, 32'h00aa_aaaa);
        repeat (3) @(posedge clock);
        chk("enable off", 32'h0, 32'(io_oe));
        wr(mcell_pkg::ADDR_OE, 32'h0055_5555);
        repeat (3) @(posedge clock);
        chk("enable on", 32'h0fff, 32'(io_oe));
        $display("test comb done");
    endtask : t_comb

    task automatic t_feedback;
        // cell 0 holds via the complement of its own feedback literal
        wr(mcell_pkg::ADDR_SEL, 32'd0);
        wr(mcell_pkg::ADDR_TERM_LO, 32'h0);
        wr(mcell_pkg::ADDR_TERM_HI, 32'h0000_0100);
        // cell 1 follows the pin of cell 2, which is an input here
        term(32'd8, 32'h0001_0000);
        wr(mcell_pkg::ADDR_OE, 32'h0000_0020);
        wr(mcell_pkg::ADDR_MODE, 32'h0001_0003);
        wr(mcell_pkg::ADDR_PRELOAD, 32'h0000_0001);
        repeat (5) @(posedge clock);
        chk("feedback holds q", 32'h1, 32'(io_out[0]));
        drv_io_en <= 12'h004;
        repeat (5) @(posedge clock);
        chk("pin feedback low", 32'h0, 32'(io_out[1]));
        drv_io_en <= 12'h000;
        repeat (5) @(posedge clock);
        chk("pin pulled up", 32'h1, 32'(io_out[1]));
        $display("test feedback done");
    endtask : t_feedback

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drv_in = 14'h0000;
        drv_in_en = 14'h3fff;
        drv_io_en = 12'h000;
        err_total = 0;
        total_checks = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_powerup;
        t_secure;
        t_preload;
        t_zero_set;
        t_comb;
        t_feedback;
        end_of_test;
    end

    initial begin
        #300000;
        err_total++;
        $display("wrong value watchdog expected done seen hang");
        end_of_test;
    end
endmodule : tb_macrocell_register_control
